/* File: bench/dtsr_top_monitor.sv */
// Bus and status checker bound to the die temperature readout
`timescale 1ns/1ps
`include "dtsr_defs.svh"
module dtsr_top_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`DTSR_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic conv_clk_out,
    input wire logic [4:0] conv_input_select
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic ar_go;
    assign ar_go = s_axi_arvalid && s_axi_arready;
    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshakes
    property p_aw_hold;
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
    endproperty
    a_aw_hold: assert property (p_aw_hold) else $error("address taken twice");
    // Pending response may delay the next one, hence the guard on bvalid
    property p_b_after;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
            |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_b_after: assert property (p_b_after) else $error("write response late");
    property p_b_stand;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_stand: assert property (p_b_stand) else $error("write response dropped");
    property p_r_answer;
        ar_go |=> s_axi_rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
    property p_r_stand;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_stand: assert property (p_r_stand) else $error("read data dropped");
    property p_ar_block;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read answer not retired");
    property p_unmapped;
        ar_go && s_axi_araddr > 8'h17 |=> s_axi_rresp == `DTSR_RESP_SLVERR;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
    ////////////////////////////////////////////////////////////////////////////////
    // Register contents
    property p_code_width;
        ar_go && s_axi_araddr == `DTSR_ADDR_CODE |=> s_axi_rdata[31:12] == 20'h00000;
    endproperty
    a_code_width: assert property (p_code_width) else $error("code too wide");
    property p_stat_excl;
        ar_go && s_axi_araddr == `DTSR_ADDR_STAT |=> !(s_axi_rdata[0] && s_axi_rdata[3]);
    endproperty
    a_stat_excl: assert property (p_stat_excl) else $error("valid while busy");
    property p_dir_over;
        ar_go && s_axi_araddr == `DTSR_ADDR_STAT |=> !s_axi_rdata[2] || s_axi_rdata[1];
    endproperty
    a_dir_over: assert property (p_dir_over) else $error("direction without flag");
    property p_tcfg_rsvd;
        ar_go && s_axi_araddr == `DTSR_ADDR_TCFG
            |=> s_axi_rdata[31:24] == 8'h00 && s_axi_rdata[19:17] == 3'h0;
    endproperty
    a_tcfg_rsvd: assert property (p_tcfg_rsvd) else $error("config spare bits set");
    property p_sel_legal;
        conv_input_select <= `DTSR_CH_EXT_MAX || conv_input_select == `DTSR_CH_SENSOR;
    endproperty
    a_sel_legal: assert property (p_sel_legal) else $error("illegal channel");
    ////////////////////////////////////////////////////////////////////////////////
    // Converter clock; a start restarts the divider, so low may stretch but high never
    property p_conv_clk;
        $fell(conv_clk_out) |-> ##[1:6] $rose(conv_clk_out);
    endproperty
    a_conv_clk: assert property (p_conv_clk) else $error("converter clock stalled");
    property p_conv_high;
        conv_clk_out [*3] |=> !conv_clk_out;
    endproperty
    a_conv_high: assert property (p_conv_high) else $error("converter clock high too long");
endmodule

bind dtsr_top dtsr_top_monitor dtsr_top_monitor_inst (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .conv_clk_out, .conv_input_select);

/* File: bench/tb.sv */
// Register-level testbench for the die temperature readout
`timescale 1ns/1ps
`include "dtsr_defs.svh"
module tb;
    // Short conversions keep the run small; limits below scale with it
    localparam int CB = 2;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [11:0] conv_code_pin = 12'h000;
    logic [7:0] fused_offset_pin = 8'hF0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, d;
    logic [4:0] conv_input_select;
    logic [1:0] r;
    logic [1:0] last_fl = 2'b00;
    logic [4:0] chs [5] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h10};
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #2 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    dtsr_top #(.CONV_BASE_CYCLES(CB)) dtsr_top_inst (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_code_pin, .fused_offset_pin,
        .conv_clk_out(), .conv_input_select);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic [1:0] rs;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        rs = 2'h3;
        // Only the watchdog ends a wait for the answer
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                rs = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        chk({30'h0, rs}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        v = 32'h0;
        rs = 2'h3;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                v = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
        logic [31:0] v;
        logic [1:0] rs;
        rd(a, v, rs);
        chk(v & m, e);
        chk({30'h0, rs}, {30'h0, er});
    endtask
    // Flags argument is {direction, over limit}
    task automatic meas(input logic [11:0] code, input logic [15:0] t, input logic [1:0] fl,
                        input int lim);
        int t0;
        conv_code_pin <= code;
        wr(`DTSR_ADDR_CTRL, 32'h1, `DTSR_RESP_OKAY);
        t0 = cyc;
        // A start clears only valid; the change flags keep the last result
        rc(`DTSR_ADDR_STAT, 32'hF, {28'h0, 1'b1, last_fl, 1'b0}, `DTSR_RESP_OKAY);
        d = 32'h0;
        while (d[0] !== 1'b1 && cyc - t0 < lim + 40) rd(`DTSR_ADDR_STAT, d, r);
        chk((cyc - t0 <= lim + 8) ? 32'h1 : 32'h0, 32'h1);
        rc(`DTSR_ADDR_READ, 32'hFFFF, {16'h0, t}, `DTSR_RESP_OKAY);
        rc(`DTSR_ADDR_STAT, 32'hF, {28'h0, 1'b0, fl, 1'b1}, `DTSR_RESP_OKAY);
        last_fl = fl;
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rc(`DTSR_ADDR_STAT, 32'hFFFFFFFF, 32'h0, `DTSR_RESP_OKAY);
        rc(`DTSR_ADDR_TCFG, 32'hFFFFFFFF, 32'h0, `DTSR_RESP_OKAY);
        rc(8'h20, 32'hFFFFFFFF, 32'h0, `DTSR_RESP_SLVERR);
        wr(8'h20, 32'h1, `DTSR_RESP_SLVERR);
        $display("test reset done");
        foreach (chs[i]) begin
            wr(`DTSR_ADDR_CONV, {21'h0, 3'h2, 3'h0, chs[i]}, `DTSR_RESP_OKAY);
            rc(`DTSR_ADDR_CONV, 32'h71F, {21'h0, 3'h2, 3'h0, chs[i]}, 2'h0);
        end
        // An illegal code must leave the sensor routed
        wr(`DTSR_ADDR_CONV, 32'h205, `DTSR_RESP_OKAY);
        rc(`DTSR_ADDR_CONV, 32'h71F, 32'h210, `DTSR_RESP_OKAY);
        $display("test channel done");
        conv_code_pin <= 12'hABC;
        repeat (120) @(posedge aclk);
        rc(`DTSR_ADDR_CODE, 32'hFFFFFFFF, 32'hABC, `DTSR_RESP_OKAY);
        $display("test code done");
        wr(`DTSR_ADDR_TCFG, 32'h00511200, `DTSR_RESP_OKAY);
        rc(`DTSR_ADDR_TCFG, 32'hFFFFFFFF, 32'h00511200, `DTSR_RESP_OKAY);
        // A single byte strobe must touch only the offset byte
        s_axi_wstrb <= 4'h2;
        wr(`DTSR_ADDR_TCFG, 32'hFFFF34FF, `DTSR_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rc(`DTSR_ADDR_TCFG, 32'hFFFFFFFF, 32'h00513400, `DTSR_RESP_OKAY);
        wr(`DTSR_ADDR_TCFG, 32'h00511200, `DTSR_RESP_OKAY);
        meas(12'h9A0, 16'h002C, 2'b00, 6 * 6 * CB);
        meas(12'hA00, 16'h0032, 2'b11, 6 * 6 * CB);
        meas(12'h9B0, 16'h002D, 2'b00, 6 * 6 * CB);
        meas(12'h940, 16'h0026, 2'b01, 6 * 6 * CB);
        repeat (100) @(posedge aclk);
        rc(`DTSR_ADDR_STAT, 32'hF, 32'h3, `DTSR_RESP_OKAY);
        wr(`DTSR_ADDR_TCFG, 32'h00501201, `DTSR_RESP_OKAY);
        meas(12'h300, 16'hFFA0, 2'b01, 6 * 6 * CB * 2);
        $display("test measure done");
        results();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        results();
    end
endmodule

/* File: core/dtsr_top.sv */
// Die temperature readout on the shared auxiliary converter, AXI4-Lite register slave
`timescale 1ns/1ps
`include "dtsr_defs.svh"

module dtsr_top
    import dtsr_pkg::*;
#(
    parameter int CONV_BASE_CYCLES = `DTSR_DECIM_BASE
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`DTSR_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`DTSR_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [11:0] conv_code_pin,
    input wire logic [7:0] fused_offset_pin,
    output logic conv_clk_out,
    output logic [4:0] conv_input_select
);

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge[i*8 +: 8] = data[i*8 +: 8];
            end
        end
    endfunction

    function automatic logic [23:0] conv_len(input logic [2:0] sel);
        conv_len = 24'(CONV_BASE_CYCLES) << sel;
    endfunction

    function automatic logic [15:0] to_celsius(input logic [11:0] code, input logic [7:0] ofs);
        to_celsius = 16'(code >> `DTSR_TEMP_SHIFT) + {{8{ofs[7]}}, ofs} - `DTSR_TEMP_BIAS;
    endfunction

    function automatic logic legal_channel(input logic [4:0] ch);
        legal_channel = (ch <= `DTSR_CH_EXT_MAX) || (ch == `DTSR_CH_SENSOR);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the code word is slow against aclk, so skew is tolerated
    logic [11:0] code_s1_r, code_s2_r;
    logic [7:0] fuse_s1_r, fuse_s2_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_s1_r <= 12'h000;
            code_s2_r <= 12'h000;
            fuse_s1_r <= 8'h00;
            fuse_s2_r <= 8'h00;
        end else begin
            code_s1_r <= conv_code_pin;
            code_s2_r <= code_s1_r;
            fuse_s1_r <= fused_offset_pin;
            fuse_s2_r <= fuse_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave and configuration
    logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
    logic [`DTSR_ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [4:0] chan_r, chan_nxt;
    logic [2:0] conv_dec_r, conv_dec_nxt;
    dtsr_tcfg_s tcfg_r, tcfg_nxt;
    logic start_req;

    dtsr_stat_s stat_r, stat_nxt;
    logic [15:0] reading_r, reading_nxt;
    logic [11:0] result_r, result_nxt;

    assign s_axi_awready = !aw_held_r;
    assign s_axi_wready = !w_held_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign conv_input_select = chan_r;

    always_comb begin
        logic [31:0] wv;
        logic [`DTSR_ADDR_W-1:0] wa, ra;
        wv = 32'h0000_0000;
        wa = {aw_addr_r[`DTSR_ADDR_W-1:2], 2'h0};
        ra = {s_axi_araddr[`DTSR_ADDR_W-1:2], 2'h0};
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt = w_held_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        chan_nxt = chan_r;
        conv_dec_nxt = conv_dec_r;
        tcfg_nxt = tcfg_r;
        start_req = 1'b0;
        if (s_axi_awvalid && !aw_held_r) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_r) begin
            w_held_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (aw_held_r && w_held_r && !bvalid_r) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = `DTSR_RESP_OKAY;
            case (wa)
                `DTSR_ADDR_CTRL: begin
                    start_req = w_strb_r[0] && w_data_r[`DTSR_CTRL_START];
                end
                `DTSR_ADDR_CONV: begin
                    wv = merge({21'h0, conv_dec_r, 3'h0, chan_r}, w_data_r, w_strb_r);
                    // Illegal codes are dropped so the mux never sees an unrouted input
                    if (legal_channel(wv[`DTSR_CONV_SEL_LSB +: 5])) begin
                        chan_nxt = wv[`DTSR_CONV_SEL_LSB +: 5];
                    end
                    conv_dec_nxt = wv[`DTSR_CONV_DEC_LSB +: 3];
                end
                `DTSR_ADDR_TCFG: begin
                    wv = merge({8'h0, tcfg_r.change_window_deg, 3'h0, tcfg_r.use_user_offset,
                                tcfg_r.offset, 5'h0, tcfg_r.temp_conv_decim_sel},
                               w_data_r, w_strb_r);
                    tcfg_nxt.temp_conv_decim_sel = wv[`DTSR_TCFG_DEC_LSB +: 3];
                    tcfg_nxt.offset = wv[`DTSR_TCFG_OFS_LSB +: 8];
                    tcfg_nxt.use_user_offset = wv[`DTSR_TCFG_USR_BIT];
                    tcfg_nxt.change_window_deg = wv[`DTSR_TCFG_WIN_LSB +: 4];
                end
                `DTSR_ADDR_STAT, `DTSR_ADDR_READ, `DTSR_ADDR_CODE: begin
                    bresp_nxt = `DTSR_RESP_OKAY;
                end
                default: begin
                    bresp_nxt = `DTSR_RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `DTSR_RESP_OKAY;
            case (ra)
                `DTSR_ADDR_CTRL: rdata_nxt = {31'h0, stat_r.busy};
                `DTSR_ADDR_CONV: rdata_nxt = {21'h0, conv_dec_r, 3'h0, chan_r};
                `DTSR_ADDR_TCFG: begin
                    rdata_nxt = {8'h0, tcfg_r.change_window_deg, 3'h0, tcfg_r.use_user_offset,
                                 tcfg_r.offset, 5'h0, tcfg_r.temp_conv_decim_sel};
                end
                `DTSR_ADDR_STAT: rdata_nxt = {28'h0, stat_r};
                `DTSR_ADDR_READ: rdata_nxt = {16'h0, reading_r};
                `DTSR_ADDR_CODE: rdata_nxt = {20'h0, result_r};
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = `DTSR_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= `DTSR_ADDR_CTRL;
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `DTSR_RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= `DTSR_RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            chan_r <= `DTSR_RST_CH;
            conv_dec_r <= `DTSR_RST_DEC;
            tcfg_r <= '{`DTSR_RST_WIN, 1'b0, `DTSR_RST_OFS, `DTSR_RST_DEC};
        end else begin
            aw_held_r <= aw_held_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_held_r <= w_held_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            chan_r <= chan_nxt;
            conv_dec_r <= conv_dec_nxt;
            tcfg_r <= tcfg_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Converter timing and measurement sequencing
    dtsr_state_e state_r, state_nxt;
    logic [2:0] div_r, div_nxt, meas_r, meas_nxt;
    logic [23:0] cyc_r, cyc_nxt;
    logic conv_clk_r, conv_clk_nxt, have_prev_r, have_prev_nxt;
    logic [15:0] prev_r, prev_nxt;

    assign conv_clk_out = conv_clk_r;

    always_comb begin
        logic tick, conv_end;
        logic [23:0] len;
        logic [15:0] cur;
        logic [16:0] diff;
        tick = (div_r == 3'(`DTSR_DIV - 1));
        conv_end = 1'b0;
        len = 24'h000000;
        cur = 16'h0000;
        diff = 17'h00000;
        div_nxt = tick ? 3'h0 : div_r + 3'h1;
        conv_clk_nxt = (div_nxt >= 3'(`DTSR_DIV / 2));
        state_nxt = state_r;
        meas_nxt = meas_r;
        cyc_nxt = cyc_r;
        have_prev_nxt = have_prev_r;
        prev_nxt = prev_r;
        stat_nxt = stat_r;
        reading_nxt = reading_r;
        result_nxt = result_r;
        len = conv_len((state_r == st_run) ? tcfg_r.temp_conv_decim_sel : conv_dec_r);
        // Starts during a measurement are ignored; the running one finishes untouched
        if (start_req && state_r == st_idle) begin
            state_nxt = st_run;
            meas_nxt = 3'h0;
            cyc_nxt = 24'h000000;
            div_nxt = 3'h0;
            stat_nxt.reading_valid_flag = 1'b0;
            stat_nxt.busy = 1'b1;
        end else if (tick) begin
            // Compare with >= so a decimation cut mid-conversion cannot overrun
            if (cyc_r >= len - 24'h000001) begin
                cyc_nxt = 24'h000000;
                conv_end = 1'b1;
            end else begin
                cyc_nxt = cyc_r + 24'h000001;
            end
        end
        if (conv_end) begin
            result_nxt = code_s2_r;
            case (state_r)
                st_run: begin
                    if (meas_r == `DTSR_MEAS_CONV - 3'h1) begin
                        cur = to_celsius(code_s2_r, tcfg_r.use_user_offset ?
                                         tcfg_r.offset : fuse_s2_r);
                        diff = {cur[15], cur} - {prev_r[15], prev_r};
                        if (diff[16]) begin
                            diff = 17'h00000 - diff;
                        end
                        reading_nxt = cur;
                        stat_nxt.reading_valid_flag = 1'b1;
                        stat_nxt.change_over_limit_flag = have_prev_r &&
                            (diff > {13'h0000, tcfg_r.change_window_deg});
                        stat_nxt.change_direction_up = have_prev_r &&
                            (diff > {13'h0000, tcfg_r.change_window_deg}) &&
                            ($signed(cur) > $signed(prev_r));
                        stat_nxt.busy = 1'b0;
                        prev_nxt = cur;
                        have_prev_nxt = 1'b1;
                        state_nxt = st_idle;
                    end else begin
                        meas_nxt = meas_r + 3'h1;
                    end
                end
                st_idle: meas_nxt = 3'h0;
                default: state_nxt = st_idle;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= st_idle;
            div_r <= 3'h0;
            meas_r <= 3'h0;
            cyc_r <= 24'h000000;
            conv_clk_r <= 1'b0;
            have_prev_r <= 1'b0;
            prev_r <= 16'h0000;
            stat_r <= 4'h0;
            reading_r <= 16'h0000;
            result_r <= 12'h000;
        end else begin
            state_r <= state_nxt;
            div_r <= div_nxt;
            meas_r <= meas_nxt;
            cyc_r <= cyc_nxt;
            conv_clk_r <= conv_clk_nxt;
            have_prev_r <= have_prev_nxt;
            prev_r <= prev_nxt;
            stat_r <= stat_nxt;
            reading_r <= reading_nxt;
            result_r <= result_nxt;
        end
    end

endmodule

/* File: shared/dtsr_defs.svh */
// Register map, field positions, reset values and timing for the die temperature readout
`ifndef DTSR_DEFS_SVH
`define DTSR_DEFS_SVH

`define DTSR_ADDR_W 8
`define DTSR_ADDR_CTRL 8'h00
`define DTSR_ADDR_CONV 8'h04
`define DTSR_ADDR_TCFG 8'h08
`define DTSR_ADDR_STAT 8'h0C
`define DTSR_ADDR_READ 8'h10
`define DTSR_ADDR_CODE 8'h14

`define DTSR_CTRL_START 0
`define DTSR_CONV_SEL_LSB 0
`define DTSR_CONV_DEC_LSB 8
`define DTSR_TCFG_DEC_LSB 0
`define DTSR_TCFG_OFS_LSB 8
`define DTSR_TCFG_USR_BIT 16
`define DTSR_TCFG_WIN_LSB 20

`define DTSR_CH_EXT_MAX 5'h03
`define DTSR_CH_SENSOR 5'h10
`define DTSR_RST_CH 5'h00
`define DTSR_RST_DEC 3'h0
`define DTSR_RST_OFS 8'h00
`define DTSR_RST_WIN 4'h0

`define DTSR_DECIM_BASE 256
`define DTSR_MEAS_CONV 3'h6
`define DTSR_ACLK_KHZ 250000
`define DTSR_CONV_KHZ 40000
`define DTSR_DIV ((`DTSR_ACLK_KHZ + `DTSR_CONV_KHZ / 2) / `DTSR_CONV_KHZ)
`define DTSR_TEMP_SHIFT 4
`define DTSR_TEMP_BIAS 16'h0080

`define DTSR_RESP_OKAY 2'h0
`define DTSR_RESP_SLVERR 2'h2

`endif

/* File: shared/dtsr_pkg.sv */
// Types shared by the die temperature readout
package dtsr_pkg;

    typedef struct packed {
        logic [3:0] change_window_deg;
        logic use_user_offset;
        logic [7:0] offset;
        logic [2:0] temp_conv_decim_sel;
    } dtsr_tcfg_s;

    typedef struct packed {
        logic busy;
        logic change_direction_up;
        logic change_over_limit_flag;
        logic reading_valid_flag;
    } dtsr_stat_s;

    typedef enum logic [0:0] {
        st_idle,
        st_run
    } dtsr_state_e;

endpackage
